// file: common/cox_defs.vh
/*
 * Constants of the operand/transfer execute block: register offsets,
 * field positions, reset values, operand ranges and cycle counts.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef COX_DEFS_VH
`define COX_DEFS_VH

// Register offsets (byte addresses, one aligned word each)
`define COX_OFF_CTRL    8'h00
`define COX_OFF_OPER    8'h04
`define COX_OFF_IMM     8'h08
`define COX_OFF_MDATA   8'h0c
`define COX_OFF_STAT    8'h10
`define COX_OFF_PSW     8'h14
`define COX_OFF_CLKSEL  8'h18
`define COX_OFF_RESULT  8'h1c
`define COX_OFF_GPR     8'h20
`define COX_OFF_GPR_END 8'h3c

// Control word fields
`define COX_CTRL_GO     10

// Status flags word bit positions
`define COX_PSW_CY      0
`define COX_PSW_AC      1
`define COX_PSW_Z       2
`define COX_PSW_RBS     3
`define COX_PSW_IE      7
`define COX_PSW_RST     8'h00
`define COX_CLKSEL_RST  3'h0

// Operand address modes
`define COX_M_NONE      3'h0
`define COX_M_SADDR     3'h1
`define COX_M_SADDRP    3'h2
`define COX_M_ADDR16    3'h3
`define COX_M_SFR       3'h4
`define COX_M_SFRP      3'h5
`define COX_M_CALL_FIELD_TARGET    3'h6
`define COX_M_CALL_TABLE_ENTRY     3'h7

// Address ranges
`define COX_SADDR_LO    16'hfe20
`define COX_SADDR_HI    16'hff1f
`define COX_SFR_LO      16'hff00
`define COX_SFR_RSV_LO  16'hffd0
`define COX_SFR_RSV_HI  16'hffdf
`define COX_SFRP_LO     16'hff10
`define COX_SFRP_HI     16'hff1f
`define COX_CALLF_LO    16'h0800
`define COX_CALLF_HI    16'h0fff
`define COX_CALLT_LO    16'h0040
`define COX_CALLT_HI    16'h007f
`define COX_HSRAM_LO    16'hfb00
`define COX_HSRAM_HI    16'hfeff

// Error codes
`define COX_E_NONE      3'h0
`define COX_E_OP        3'h1
`define COX_E_RANGE     3'h2
`define COX_E_ODD       3'h3
`define COX_E_RSV       3'h4
`define COX_E_PAIR      3'h5
`define COX_E_MODE      3'h6

// Instruction cycle counts (short = fast RAM or no access, long = other)
`define COX_CYC_REG     8'h02
`define COX_CYC_IMM     8'h04
`define COX_CYC_PSWI    8'h07
`define COX_CYC_PSWA    8'h05
`define COX_CYC_B_S     8'h04
`define COX_CYC_B_L     8'h05
`define COX_CYC_B16_S   8'h08
`define COX_CYC_B16_L   8'h09
`define COX_CYC_X_S     8'h04
`define COX_CYC_X_L     8'h06
`define COX_CYC_X16_S   8'h08
`define COX_CYC_X16_L   8'h0a
`define COX_CYC_WI      8'h06
`define COX_CYC_WR      8'h04
`define COX_CYC_W_S     8'h06
`define COX_CYC_W_L     8'h08
`define COX_CYC_W16_S   8'h0a
`define COX_CYC_W16_L   8'h0c

`endif

// file: verilog/cox_opchk.v
/*
 * Operand address checker: judges an address against its operand mode
 * and tells whether the access falls outside fast internal RAM.
 * Assumes a purely combinational use by the execute block.
 */
`timescale 1ns/1ps
`include "cox_defs.vh"

module cox_opchk (
  // Operand to judge
  input  wire [2:0]  mode,
  input  wire [15:0] addr,
  input  wire        word_xfer,
  // Verdict
  output reg  [2:0]  err,
  output wire        long_acc
);

  // Inclusive range test, used for every window except the open-ended special register one
  function in_rng;
    input [15:0] a;
    input [15:0] lo;
    input [15:0] hi;
    begin
      in_rng = (a >= lo) && (a <= hi);
    end
  endfunction

  // Special registers and anything outside fast RAM take the long count
  assign long_acc = (mode == `COX_M_SFR) || (mode == `COX_M_SFRP) ||
                    !in_rng(addr, `COX_HSRAM_LO, `COX_HSRAM_HI);

  // Mode-specific legality
  always @* begin
    err = `COX_E_NONE;
    case (mode)
      `COX_M_SADDR: begin
        if (!in_rng(addr, `COX_SADDR_LO, `COX_SADDR_HI))
          err = `COX_E_RANGE;
      end
      `COX_M_SADDRP: begin
        if (!in_rng(addr, `COX_SADDR_LO, `COX_SADDR_HI))
          err = `COX_E_RANGE;
        else if (addr[0])
          err = `COX_E_ODD;
      end
      `COX_M_ADDR16: begin
        if (word_xfer && addr[0])
          err = `COX_E_ODD;
      end
      `COX_M_SFR: begin
        if (addr < `COX_SFR_LO)
          err = `COX_E_RANGE;
        else if (in_rng(addr, `COX_SFR_RSV_LO, `COX_SFR_RSV_HI))
          err = `COX_E_RSV;
      end
      `COX_M_SFRP: begin
        if (in_rng(addr, `COX_SFR_RSV_LO, `COX_SFR_RSV_HI))
          err = `COX_E_RSV;
        else if (!in_rng(addr, `COX_SFRP_LO, `COX_SFRP_HI))
          err = `COX_E_RANGE;
        else if (addr[0])
          err = `COX_E_ODD;
      end
      `COX_M_CALL_FIELD_TARGET: begin
        if (!in_rng(addr, `COX_CALLF_LO, `COX_CALLF_HI))
          err = `COX_E_RANGE;
      end
      `COX_M_CALL_TABLE_ENTRY: begin
        if (!in_rng(addr, `COX_CALLT_LO, `COX_CALLT_HI))
          err = `COX_E_RANGE;
        else if (addr[0])
          err = `COX_E_ODD;
      end
      default: err = `COX_E_NONE;
    endcase
  end

endmodule

// file: verilog/cox_exec.v
/*
 * Operand and transfer execute unit with an APB register port.
 * Software loads an instruction descriptor, starts it, and reads back
 * the register file, status flags word, store data and cycle count.
 * Assumes one clock pclk, asynchronous active-low reset presetn and a
 * well-behaved APB master; memory read data is supplied in MDATA.
 */
//////////////////////////////////////////////////////////////////////
// Function
// - byte register field 0..7 selects X,A,C,B,E,D,L,H; A is 1.
// - pair field 0..3 selects AX, BC, DE, HL.
// - short direct operands only within FE20H..FF1FH.
// - word short direct operands only at even addresses.
// - absolute addresses span whole space; word transfers need even ones.
// - call field target only within 0800H..0FFFH.
// - call table entry only at even addresses 0040H..007FH.
// - word special registers only if word-capable and even.
// - special register operands never reach FFD0H..FFDFH.
// - bit position is 3 bits; four register banks 0..3.
// - relative branch displacement is signed 8 bits.
// - A is byte accumulator, AX word accumulator; pairs split high/low.
// - each flag is kept, cleared, set, computed or restored.
// - add sums accumulator, operand, carry in; updates Z, AC, CY.
// - fast RAM or no data access uses the short cycle count.
// - any other area, all special registers, uses the long count.
// - one instruction cycle is one selected CPU clock period.
// - word transfer/exchange with AX only against BC, DE or HL.
//////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`include "cox_defs.vh"

module cox_exec (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Execution state
  output reg         cpu_busy
);

  // Opcodes of the descriptor
  localparam [4:0] OP_MOV_RI = 5'h00, OP_MOV_AR = 5'h01, OP_MOV_RA = 5'h02;
  localparam [4:0] OP_MOV_AM = 5'h03, OP_MOV_MA = 5'h04, OP_MOV_PI = 5'h05;
  localparam [4:0] OP_MOV_AP = 5'h06, OP_MOV_PA = 5'h07, OP_XCH_AR = 5'h08;
  localparam [4:0] OP_XCH_AM = 5'h09, OP_MVW_RI = 5'h0a, OP_MVW_AR = 5'h0b;
  localparam [4:0] OP_MVW_RA = 5'h0c, OP_MVW_AM = 5'h0d, OP_MVW_MA = 5'h0e;
  localparam [4:0] OP_EXCHANGE_WORD_OP   = 5'h0f, OP_ADD_I  = 5'h10, OP_ADC_I  = 5'h11;
  localparam [4:0] OP_ADD_R  = 5'h12, OP_ADC_R  = 5'h13, OP_ADD_M  = 5'h14;
  localparam [4:0] OP_ADC_M  = 5'h15, OP_SET_CY = 5'h16, OP_CLR_CY = 5'h17;
  localparam [4:0] OP_RESTOR = 5'h18, OP_TARGET = 5'h19;

  // Flag update modes
  localparam [2:0] F_KEEP = 3'h0, F_CLR = 3'h1, F_SET = 3'h2;
  localparam [2:0] F_RES  = 3'h3, F_RST = 3'h4;

  // Sequencer states
  localparam [1:0] ST_IDLE = 2'h0, ST_CHECK = 2'h1, ST_RUN = 2'h2;

  localparam [2:0] R_X = 3'h0, R_A = 3'h1;

  //////////////////////////////////////////////////////////////////////
  // Storage
  reg  [7:0]  gpr_mem [0:31];
  reg  [10:0] ctrl_reg;
  reg  [18:0] oper_reg;
  reg  [15:0] imm_reg;
  reg  [15:0] mdata_reg;
  reg  [7:0]  psw_reg;
  reg  [7:0]  psw_save_reg;
  reg  [2:0]  clksel_reg;
  reg  [15:0] result_reg;
  reg  [1:0]  state_reg;
  reg  [11:0] cnt_reg;
  reg  [7:0]  cyc_reg;
  reg  [2:0]  err_reg;
  reg         done_reg;
  reg         mem_wr_reg;
  integer     i;

  // Descriptor fields
  wire [4:0]  c_op   = ctrl_reg[4:0];
  wire [2:0]  c_r    = ctrl_reg[7:5];
  wire [1:0]  c_rp   = ctrl_reg[9:8];
  wire [15:0] o_addr = oper_reg[15:0];
  wire [2:0]  o_mode = oper_reg[18:16];
  wire [1:0]  bank   = psw_reg[`COX_PSW_RBS+1:`COX_PSW_RBS];

  // Bank-relative register index
  function [4:0] gidx;
    input [1:0] bk;
    input [2:0] r;
    begin
      gidx = {bk, r};
    end
  endfunction

  // Apply one flag update mode
  function flag_apply;
    input [2:0] md;
    input       old;
    input       res;
    input       saved;
    begin
      case (md)
        F_CLR:   flag_apply = 1'b0;
        F_SET:   flag_apply = 1'b1;
        F_RES:   flag_apply = res;
        F_RST:   flag_apply = saved;
        default: flag_apply = old;
      endcase
    end
  endfunction

  // Operand reads; pair n is low register 2n, high register 2n+1
  wire [7:0] val_a  = gpr_mem[gidx(bank, R_A)];
  wire [7:0] val_x  = gpr_mem[gidx(bank, R_X)];
  wire [7:0] val_r  = gpr_mem[gidx(bank, c_r)];
  wire [4:0] lo_idx = gidx(bank, {c_rp, 1'b0});
  wire [4:0] hi_idx = gidx(bank, {c_rp, 1'b1});
  wire [7:0] rp_lo  = gpr_mem[lo_idx];
  wire [7:0] rp_hi  = gpr_mem[hi_idx];

  //////////////////////////////////////////////////////////////////////
  // Operand address check
  wire        is_word = (c_op == OP_MVW_AM) || (c_op == OP_MVW_MA);
  wire [2:0]  chk_err;
  wire        chk_long;

  cox_opchk u_chk (
    .mode      (o_mode),
    .addr      (o_addr),
    .word_xfer (is_word),
    .err       (chk_err),
    .long_acc  (chk_long)
  );

  // Memory-operand classes and the modes each accepts
  wire m_byte = (c_op == OP_MOV_AM) || (c_op == OP_MOV_MA) || (c_op == OP_XCH_AM);
  wire m_add  = (c_op == OP_ADD_M) || (c_op == OP_ADC_M);
  wire mode_bad =
    (m_byte && !(o_mode == `COX_M_SADDR || o_mode == `COX_M_SFR ||
                 o_mode == `COX_M_ADDR16)) ||
    (m_add && !(o_mode == `COX_M_SADDR || o_mode == `COX_M_ADDR16)) ||
    (is_word && !(o_mode == `COX_M_SADDRP || o_mode == `COX_M_SFRP ||
                  o_mode == `COX_M_ADDR16)) ||
    ((c_op == OP_TARGET) && !(o_mode == `COX_M_NONE ||
                  o_mode == `COX_M_CALL_FIELD_TARGET || o_mode == `COX_M_CALL_TABLE_ENTRY));
  wire needs_pair = (c_op == OP_MVW_AR) || (c_op == OP_MVW_RA) || (c_op == OP_EXCHANGE_WORD_OP);
  wire r_is_a     = ((c_op == OP_ADD_R) || (c_op == OP_ADC_R)) && (c_r == R_A);

  // Verdict on the whole descriptor, opcode check first, then pair
  wire [2:0] dec_err =
    (c_op > OP_TARGET)            ? `COX_E_OP :
    (needs_pair && (c_rp == 2'h0)) ? `COX_E_PAIR :
    r_is_a                        ? `COX_E_OP :
    mode_bad                      ? `COX_E_MODE : chk_err;

  // Instruction cycles per opcode and access class
  function [7:0] cyc_of;
    input [4:0] op;
    input [2:0] md;
    input       lng;
    reg         a16;
    begin
      a16 = (md == `COX_M_ADDR16);
      case (op)
        OP_MOV_RI, OP_ADD_I, OP_ADC_I, OP_ADD_R, OP_ADC_R: cyc_of = `COX_CYC_IMM;
        OP_MOV_AR, OP_MOV_RA, OP_XCH_AR, OP_SET_CY, OP_CLR_CY,
        OP_RESTOR, OP_TARGET:                              cyc_of = `COX_CYC_REG;
        OP_MOV_PI:                                         cyc_of = `COX_CYC_PSWI;
        OP_MOV_AP, OP_MOV_PA:                              cyc_of = `COX_CYC_PSWA;
        OP_MVW_RI:                                         cyc_of = `COX_CYC_WI;
        OP_MVW_AR, OP_MVW_RA, OP_EXCHANGE_WORD_OP:                     cyc_of = `COX_CYC_WR;
        OP_MOV_AM, OP_MOV_MA, OP_ADD_M, OP_ADC_M:
          cyc_of = a16 ? (lng ? `COX_CYC_B16_L : `COX_CYC_B16_S)
                       : (lng ? `COX_CYC_B_L : `COX_CYC_B_S);
        OP_XCH_AM:
          cyc_of = a16 ? (lng ? `COX_CYC_X16_L : `COX_CYC_X16_S)
                       : (lng ? `COX_CYC_X_L : `COX_CYC_X_S);
        OP_MVW_AM, OP_MVW_MA:
          cyc_of = a16 ? (lng ? `COX_CYC_W16_L : `COX_CYC_W16_S)
                       : (lng ? `COX_CYC_W_L : `COX_CYC_W_S);
        default: cyc_of = `COX_CYC_REG;
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Adder: accumulator + operand + optional carry in
  wire       with_cy = (c_op == OP_ADC_I) || (c_op == OP_ADC_R) || (c_op == OP_ADC_M);
  wire [7:0] add_b   = ((c_op == OP_ADD_I) || (c_op == OP_ADC_I)) ? imm_reg[7:0] :
                       ((c_op == OP_ADD_R) || (c_op == OP_ADC_R)) ? val_r :
                       mdata_reg[7:0];
  wire       cin     = with_cy & psw_reg[`COX_PSW_CY];
  wire [8:0] sum9    = {1'b0, val_a} + {1'b0, add_b} + {8'h00, cin};
  wire [4:0] sum5    = {1'b0, val_a[3:0]} + {1'b0, add_b[3:0]} + {4'h0, cin};
  wire       is_add  = (c_op >= OP_ADD_I) && (c_op <= OP_ADC_M);

  // Flag modes per opcode; plain moves and exchanges keep all flags
  wire       ld_psw  = (c_op == OP_MOV_PI) || (c_op == OP_MOV_PA);
  wire [2:0] fm_zac  = (is_add || ld_psw) ? F_RES :
                       (c_op == OP_RESTOR) ? F_RST : F_KEEP;
  wire [2:0] fm_cy   = (is_add || ld_psw) ? F_RES :
                       (c_op == OP_SET_CY) ? F_SET :
                       (c_op == OP_CLR_CY) ? F_CLR :
                       (c_op == OP_RESTOR) ? F_RST : F_KEEP;
  // Loaded status byte supplies the result flags of a status load
  wire [7:0] ld_byte = (c_op == OP_MOV_PI) ? imm_reg[7:0] : val_a;
  wire       res_z   = ld_psw ? ld_byte[`COX_PSW_Z]  : (sum9[7:0] == 8'h00);
  wire       res_ac  = ld_psw ? ld_byte[`COX_PSW_AC] : sum5[4];
  wire       res_cy  = ld_psw ? ld_byte[`COX_PSW_CY] : sum9[8];

  // Relative targets use a sign-extended displacement
  wire [15:0] rel_tgt = o_addr + {{8{imm_reg[7]}}, imm_reg[7:0]};

  //////////////////////////////////////////////////////////////////////
  // APB decode; no wait state, yet every answer leaves a flip-flop
  wire apb_acc = psel & penable & pready;
  wire apb_wr  = apb_acc & pwrite;
  wire is_gpr  = (paddr >= `COX_OFF_GPR) && (paddr <= `COX_OFF_GPR_END) &&
                 (paddr[1:0] == 2'b00);
  wire mapped  = is_gpr || (paddr[1:0] == 2'b00 && paddr <= `COX_OFF_RESULT);
  wire [4:0] sw_idx = gidx(bank, paddr[4:2]);
  wire go      = apb_wr && (paddr == `COX_OFF_CTRL) && pwdata[`COX_CTRL_GO] &&
                 (state_reg == ST_IDLE);
  // Descriptor and register file are frozen while an instruction runs
  wire sw_ok   = apb_wr && (state_reg == ST_IDLE);

  // Read mux, sampled in the setup cycle
  reg [31:0] rd_next;
  always @* begin
    rd_next = 32'h0000_0000;
    case (paddr)
      `COX_OFF_CTRL:   rd_next = {21'h0, 1'b0, ctrl_reg[9:0]};
      `COX_OFF_OPER:   rd_next = {13'h0, oper_reg};
      `COX_OFF_IMM:    rd_next = {16'h0, imm_reg};
      `COX_OFF_MDATA:  rd_next = {16'h0, mdata_reg};
      `COX_OFF_STAT:   rd_next = {16'h0, cyc_reg, 1'b0, err_reg, 1'b0, mem_wr_reg,
                                  done_reg, cpu_busy};
      `COX_OFF_PSW:    rd_next = {24'h0, psw_reg};
      `COX_OFF_CLKSEL: rd_next = {29'h0, clksel_reg};
      `COX_OFF_RESULT: rd_next = {16'h0, result_reg};
      default:         rd_next = is_gpr ? {24'h0, gpr_mem[sw_idx]} : 32'h0000_0000;
    endcase
  end

  // Bus answer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel & ~penable)
        prdata <= rd_next;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Sequencer, register file and commit
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < 32; i = i + 1)
        gpr_mem[i] <= 8'h00;
      ctrl_reg     <= 11'h000;
      oper_reg     <= 19'h00000;
      imm_reg      <= 16'h0000;
      mdata_reg    <= 16'h0000;
      psw_reg      <= `COX_PSW_RST;
      psw_save_reg <= `COX_PSW_RST;
      clksel_reg   <= `COX_CLKSEL_RST;
      result_reg   <= 16'h0000;
      state_reg    <= ST_IDLE;
      cnt_reg      <= 12'h000;
      cyc_reg      <= 8'h00;
      err_reg      <= `COX_E_NONE;
      done_reg     <= 1'b0;
      mem_wr_reg   <= 1'b0;
      cpu_busy     <= 1'b0;
    end else begin
      // Software writes while idle
      if (sw_ok && mapped) begin
        case (paddr)
          `COX_OFF_CTRL:   ctrl_reg   <= pwdata[10:0];
          `COX_OFF_OPER:   oper_reg   <= pwdata[18:0];
          `COX_OFF_IMM:    imm_reg    <= pwdata[15:0];
          `COX_OFF_MDATA:  mdata_reg  <= pwdata[15:0];
          `COX_OFF_PSW:    psw_reg    <= pwdata[7:0];
          `COX_OFF_CLKSEL: clksel_reg <= pwdata[2:0];
          default: begin
            if (is_gpr)
              gpr_mem[sw_idx] <= pwdata[7:0];
          end
        endcase
      end
      case (state_reg)
        ST_IDLE: begin
          if (go) begin
            state_reg  <= ST_CHECK;
            cpu_busy   <= 1'b1;
            done_reg   <= 1'b0;
            mem_wr_reg <= 1'b0;
            err_reg    <= `COX_E_NONE;
            if (pwdata[4:0] != OP_RESTOR)
              psw_save_reg <= psw_reg;
          end
        end
        ST_CHECK: begin
          cyc_reg <= cyc_of(c_op, o_mode, chk_long);
          if (dec_err != `COX_E_NONE) begin
            err_reg   <= dec_err;
            done_reg  <= 1'b1;
            cpu_busy  <= 1'b0;
            state_reg <= ST_IDLE;
          end else begin
            // Each instruction cycle spans 2^sel bus clocks
            cnt_reg   <= ({4'h0, cyc_of(c_op, o_mode, chk_long)} << clksel_reg)
                         - 12'h001;
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (cnt_reg != 12'h000) begin
            cnt_reg <= cnt_reg - 12'h001;
          end else begin
            state_reg <= ST_IDLE;
            cpu_busy  <= 1'b0;
            done_reg  <= 1'b1;
            // Flags: Z and AC share one update mode, CY follows its own
            psw_reg[`COX_PSW_Z]  <= flag_apply(fm_zac, psw_reg[`COX_PSW_Z], res_z,
                                               psw_save_reg[`COX_PSW_Z]);
            psw_reg[`COX_PSW_AC] <= flag_apply(fm_zac, psw_reg[`COX_PSW_AC], res_ac,
                                               psw_save_reg[`COX_PSW_AC]);
            psw_reg[`COX_PSW_CY] <= flag_apply(fm_cy, psw_reg[`COX_PSW_CY], res_cy,
                                               psw_save_reg[`COX_PSW_CY]);
            case (c_op)
              OP_MOV_RI: gpr_mem[gidx(bank, c_r)] <= imm_reg[7:0];
              OP_MOV_AR: gpr_mem[gidx(bank, R_A)] <= val_r;
              OP_MOV_RA: gpr_mem[gidx(bank, c_r)] <= val_a;
              OP_MOV_AM: gpr_mem[gidx(bank, R_A)] <= mdata_reg[7:0];
              OP_MOV_MA: begin
                mdata_reg  <= {8'h00, val_a};
                mem_wr_reg <= 1'b1;
              end
              OP_MOV_PI, OP_MOV_PA: begin
                // Non-flag bits load too; flags come through flag_apply
                psw_reg[7:3] <= ld_byte[7:3];
              end
              OP_MOV_AP: gpr_mem[gidx(bank, R_A)] <= psw_reg;
              OP_XCH_AR: begin
                gpr_mem[gidx(bank, R_A)] <= val_r;
                gpr_mem[gidx(bank, c_r)] <= val_a;
              end
              OP_XCH_AM: begin
                gpr_mem[gidx(bank, R_A)] <= mdata_reg[7:0];
                mdata_reg  <= {8'h00, val_a};
                mem_wr_reg <= 1'b1;
              end
              OP_MVW_RI: begin
                gpr_mem[lo_idx] <= imm_reg[7:0];
                gpr_mem[hi_idx] <= imm_reg[15:8];
              end
              OP_MVW_AR: begin
                gpr_mem[gidx(bank, R_X)] <= rp_lo;
                gpr_mem[gidx(bank, R_A)] <= rp_hi;
              end
              OP_MVW_RA: begin
                gpr_mem[lo_idx] <= val_x;
                gpr_mem[hi_idx] <= val_a;
              end
              OP_MVW_AM: begin
                gpr_mem[gidx(bank, R_X)] <= mdata_reg[7:0];
                gpr_mem[gidx(bank, R_A)] <= mdata_reg[15:8];
              end
              OP_MVW_MA: begin
                mdata_reg  <= {val_a, val_x};
                mem_wr_reg <= 1'b1;
              end
              OP_EXCHANGE_WORD_OP: begin
                // All four bytes swap in the same edge
                gpr_mem[gidx(bank, R_X)] <= rp_lo;
                gpr_mem[gidx(bank, R_A)] <= rp_hi;
                gpr_mem[lo_idx]          <= val_x;
                gpr_mem[hi_idx]          <= val_a;
              end
              OP_ADD_I, OP_ADC_I, OP_ADD_R, OP_ADC_R, OP_ADD_M, OP_ADC_M:
                gpr_mem[gidx(bank, R_A)] <= sum9[7:0];
              OP_TARGET:
                result_reg <= (o_mode == `COX_M_NONE) ? rel_tgt : o_addr;
              default: result_reg <= result_reg;
            endcase
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule

// file: dv/cox_exec_sva.sv
/* Port assertions for cox_exec: bus timing, error reads, go and busy.
   Assumes one clock pclk and async active-low presetn. */
`timescale 1ns/1ps
module cox_exec_sva (
  // Bus and state
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        cpu_busy
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Accepted go write while idle
  wire go = psel && penable && pready && pwrite && paddr == 8'h00 && pwdata[10] && !cpu_busy;
  // Bus answers, one cycle wide
  AST_RDY_SETUP: assert property (psel && !penable |=> pready) else $error("late ready");
  AST_RDY_ONE: assert property (pready |=> !pready) else $error("ready too long");
  AST_RDY_CAUSE: assert property (pready |-> $past(psel) && !$past(penable)) else $error("stray ready");
  AST_ERR_RDY: assert property (pslverr |-> pready) else $error("error without ready");
  AST_ERR_RD0: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("bad error data");
  AST_RD_HOLD: assert property (!(psel && !penable) |=> $stable(prdata)) else $error("data moved");
  // Execution starts only from a go write
  AST_GO_BUSY:
    assert property (go |=> cpu_busy) else $error("go not started");
  AST_BUSY_CAUSE:
    assert property ($rose(cpu_busy) |-> $past(go)) else $error("busy without go");
endmodule
bind cox_exec cox_exec_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .cpu_busy(cpu_busy));

// file: dv/cox_apb_host.sv
/* APB master model facing the execute block.
   Assumes callers wait for reset release before the first transfer. */
`timescale 1ns/1ps
module cox_apb_host (
  // Bus
  input  wire        pclk,
  output reg         psel,
  output reg         penable,
  output reg         pwrite,
  output reg  [7:0]  paddr,
  output reg  [31:0] pwdata,
  input  wire [31:0] prdata,
  input  wire        pready,
  input  wire        pslverr
);
  reg err;
  initial {psel, penable, pwrite, paddr, pwdata} = 43'h0;
  // One transfer; request held until ready is sampled
  task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] r);
    begin
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
    end
  endtask
endmodule

// file: dv/test_cox_exec.sv
/* Bench of cox_exec: descriptor table, then arithmetic, exchange,
   clock-select and bus cases. Assumes cox_apb_host drives the bus. */
`timescale 1ns/1ps
`include "cox_defs.vh"
module test_cox_exec;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  wire        psel, penable, pwrite, pready, pslverr, cpu_busy;
  wire [7:0]  paddr;
  wire [31:0] pwdata, prdata;
  reg  [31:0] q;
  reg  [43:0] row [0:12];
  integer     fail_count = 0;
  integer     checks = 0;
  integer     cyc = 0;
  integer     bcnt = 0;
  integer     i;
  cox_exec DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_busy(cpu_busy));
  cox_apb_host h (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // Clock, watchdog, busy length
  always #2 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cpu_busy === 1'b1) bcnt = bcnt + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      report_and_stop;
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    h.xfer(1'b1, a, d, q);
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      h.xfer(1'b0, a, 32'h0, q);
      chk(q, e);
    end
  endtask
  // Operand, go, then poll status until idle
  task run(input [11:0] c, input [19:0] o);
    begin
      wr(8'h04, {12'h0, o});
      wr(8'h00, {20'h0, c});
      q = 32'h1;
      while (q[0] === 1'b1) h.xfer(1'b0, 8'h10, 32'h0, q);
    end
  endtask
  task report_and_stop;
    begin
      $display("checks=%0d mismatches=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  // Rows: control, operand, error code, instruction cycles
  initial begin
    row[0] = {12'h420, 20'h00000, 4'h0, `COX_CYC_IMM};
    row[1] = {12'h403, 20'h1fe20, 4'h0, `COX_CYC_B_S};
    row[2] = {12'h403, 20'h1ff1f, 4'h0, `COX_CYC_B_L};
    row[3] = {12'h403, 20'h31234, 4'h0, `COX_CYC_B16_L};
    row[4] = {12'h403, 20'h1ff20, 4'h2, 8'h0};
    row[5] = {12'h40d, 20'h31235, 4'h3, 8'h0};
    row[6] = {12'h40d, 20'h2fe21, 4'h3, 8'h0};
    row[7] = {12'h40d, 20'h5ff13, 4'h3, 8'h0};
    row[8] = {12'h403, 20'h4ffd4, 4'h4, 8'h0};
    row[9] = {12'h419, 20'h607ff, 4'h2, 8'h0};
    row[10] = {12'h419, 20'h70041, 4'h3, 8'h0};
    row[11] = {12'h419, 20'h70080, 4'h2, 8'h0};
    row[12] = {12'h40b, 20'h00000, 4'h5, 8'h0};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h14, 32'h0);
    rd(8'h18, 32'h0);
    for (i = 0; i < 13; i = i + 1) begin
      run(row[i][43:32], row[i][31:12]);
      chk({29'h0, q[6:4]}, {28'h0, row[i][11:8]});
      if (row[i][11:8] == 4'h0) chk({24'h0, q[15:8]}, {24'h0, row[i][7:0]});
    end
    $display("descriptor table done");
    // Carry in used by add with carry, ignored by plain add
    wr(8'h24, 32'hff);
    wr(8'h14, 32'h01);
    wr(8'h08, 32'h00);
    run(12'h411, 20'h0);
    rd(8'h24, 32'h00);
    rd(8'h14, 32'h07);
    wr(8'h08, 32'h01);
    run(12'h410, 20'h0);
    rd(8'h24, 32'h01);
    // Exchange A with C, pair load into BC, status load
    wr(8'h28, 32'h5a);
    run(12'h448, 20'h0);
    rd(8'h24, 32'h5a);
    rd(8'h28, 32'h01);
    rd(8'h14, 32'h00);
    wr(8'h08, 32'h1234);
    run(12'h50a, 20'h0);
    rd(8'h28, 32'h34);
    rd(8'h2c, 32'h12);
    wr(8'h08, 32'h05);
    run(12'h405, 20'h0);
    rd(8'h14, 32'h05);
    // Clear carry, then restore the flags saved at that go
    run(12'h417, 20'h0);
    rd(8'h14, 32'h04);
    run(12'h418, 20'h0);
    rd(8'h14, 32'h05);
    // Halved CPU clock doubles the run cycles; busy adds one check cycle
    wr(8'h18, 32'h1);
    bcnt = 0;
    run(12'h420, 20'h0);
    chk(bcnt, {`COX_CYC_IMM, 1'b0} + 32'h1);
    // Bank 1 has its own A; bank 0 keeps the loaded one
    wr(8'h14, 32'h08);
    wr(8'h24, 32'h77);
    rd(8'h24, 32'h77);
    wr(8'h14, 32'h00);
    rd(8'h24, 32'h05);
    // Relative target with negative displacement, then a call target
    wr(8'h08, 32'h80);
    run(12'h419, 20'h01000);
    rd(8'h1c, 32'h0f80);
    run(12'h419, 20'h60800);
    rd(8'h1c, 32'h0800);
    // Unmapped address
    rd(8'h40, 32'h0);
    chk({31'h0, h.err}, 32'h1);
    // Reset in mid-instruction clears status and clock select
    wr(8'h00, 32'h420);
    @(posedge pclk) presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h10, 32'h0);
    rd(8'h18, 32'h0);
    $display("hand cases done");
    report_and_stop;
  end
endmodule
